/* File: rtl/timer_pkg.sv */
package timer_pkg;

	localparam int unsigned CTRL_W        = 9;
	localparam logic [4:0]  OFS_CTRL      = 5'h00;
	localparam logic [4:0]  OFS_TRIG      = 5'h04;
	localparam logic [4:0]  OFS_TIMER     = 5'h08;
	localparam logic [4:0]  OFS_STATUS    = 5'h0c;
	localparam int unsigned ST_IRQ        = 0;
	localparam int unsigned ST_ACTIVE     = 1;
	localparam int unsigned ST_OUT        = 2;
	localparam logic [15:0] TIMER_RESET   = 16'h0000;
	localparam logic [15:0] CNT_MAX       = 16'hffff;
	localparam logic [2:0]  DIV8_LAST     = 3'h7;
	localparam logic [4:0]  DIV32_LAST    = 5'h1f;
	// period of 2^16-1 ticks: phase runs 0..fffe
	localparam logic [15:0] PWM16_LAST    = 16'hfffe;
	// period of 2^8-1 prescaled steps
	localparam logic [7:0]  PWM8_LAST     = 8'hfe;
	localparam int unsigned CH_NORMAL     = 2;
	localparam int unsigned CH_SELECT     = 3;
	localparam int unsigned CH_X4         = 4;

	typedef enum logic [1:0] {MODE_QUAD, MODE_ONESHOT, MODE_PWM16, MODE_PWM8} mode_t;
	typedef enum logic [2:0] {TRIG_SW, TRIG_FALL, TRIG_RISE, TRIG_PREV, TRIG_NEXT} trig_t;
	typedef enum logic [1:0] {SRC_DIV1, SRC_DIV8, SRC_DIV32, SRC_SUB32} src_t;
	typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_ACTIVE} chan_state_t;

	typedef struct packed {
		logic  quadX4;
		src_t  src;
		trig_t trig;
		mode_t mode;
		logic  run;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = ctrl_t'(9'h000);

endpackage : timer_pkg

/* File: rtl/multimode_timer_channel.sv */
// Behaviour
// - two-phase x4 mode counts every effective phase edge while run is set
// - free-run underflow wraps without reload and sets the request flag
// - free-run overflow wraps without reload and sets the request flag
// - up/down decided by which phase edges and the other phase level
// - channel three selects x4 decoding; channel two normal only; channel four x4 only
// - one-shot trigger with run set starts down count and drives output high
// - one-shot reaching zero: output low, reload, stop, set request flag
// - retrigger while counting reloads at the next count-source tick
// - one-shot run cleared: stop, reload, output low, set request flag
// - start condition selects pin fall, pin rise, neighbour overflow or software
// - 16-bit PWM rising trigger with run set starts count, output high
// - PWM output falls after high time and sets request flag then
// - PWM counter reloads every period and keeps counting
// - PWM run cleared freezes counter and forces output low
// - 16-bit PWM period 2^16-1 ticks, high time n ticks
// - 16-bit PWM with value zero keeps output low
// - 8-bit PWM period (m+1)(2^8-1) ticks, high n(m+1) ticks
// - 8-bit PWM with upper byte zero keeps output low
// - 8-bit PWM first holds output low for one high width after trigger
// - 8-bit PWM falling trigger with run set starts the down count
// - count source is div1, div8, div32 or subclock div32
`timescale 1ns/1ps
module multimode_timer_channel #(
	parameter int unsigned CHANNEL = 3
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        timerInputPin,
	input  wire logic        timerOutputPinIn,
	output logic             timerOutputPinOut,
	output logic             timerOutputPinOe,
	input  wire logic        subclk,
	input  wire logic        previousChannelOvf,
	input  wire logic        nextChannelOvf,
	output logic             channelOvf,
	output logic             irqReq
);
	import timer_pkg::*;

	function automatic logic [31:0] byteMask(input logic [3:0] sel);
		byteMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : byteMask

	////////////////////////////////////////////////////////////////
	// pin synchronisers, edges
	logic [2:0]  inSh_q, outSh_q, subSh_q;
	logic        inLvl, outLvl, inRise, inFall, outRise, outFall, subRise;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			inSh_q  <= 3'h0;
			outSh_q <= 3'h0;
			subSh_q <= 3'h0;
		end else begin
			inSh_q  <= {inSh_q[1:0], timerInputPin};
			outSh_q <= {outSh_q[1:0], timerOutputPinIn};
			subSh_q <= {subSh_q[1:0], subclk};
		end
	end

	// only stages 1 and 2 are looked at; stage 0 is the metastable one
	assign inLvl   = inSh_q[1];
	assign outLvl  = outSh_q[1];
	assign inRise  = inSh_q[1] & ~inSh_q[2];
	assign inFall  = ~inSh_q[1] & inSh_q[2];
	assign outRise = outSh_q[1] & ~outSh_q[2];
	assign outFall = ~outSh_q[1] & outSh_q[2];
	assign subRise = subSh_q[1] & ~subSh_q[2];

	////////////////////////////////////////////////////////////////
	// count-source dividers
	logic [4:0] presc_q, subDiv_q;
	logic       tick;
	ctrl_t      ctrl_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			presc_q  <= 5'h00;
			subDiv_q <= 5'h00;
		end else begin
			presc_q  <= presc_q + 5'h01;
			if (subRise)
				subDiv_q <= subDiv_q + 5'h01;
		end
	end

	assign tick = (ctrl_q.src == SRC_DIV1)  ? 1'b1 :
	              (ctrl_q.src == SRC_DIV8)  ? (presc_q[2:0] == DIV8_LAST) :
	              (ctrl_q.src == SRC_DIV32) ? (presc_q == DIV32_LAST) :
	              (subRise && subDiv_q == DIV32_LAST);

	////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after the request, then one idle cycle
	logic [15:0] reload_q, cnt_q, cnt_d, phase_q, phase_d;
	logic [7:0]  pre_q, pre_d;
	logic        ack_q, req, wr, ctrlWr, timerWr, trigWr, statWr;
	logic [31:0] dat_q, rdData, ctrlMerged, timerMerged;
	logic        irq_q, out_q, out_d, oe_q, ovf_q, ovf_d, pend_q, pend_d, runPrev_q;
	chan_state_t state_q, state_d;

	assign req         = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr          = req & wb_we_i;
	assign ctrlWr      = wr && wb_adr_i[4:2] == OFS_CTRL[4:2];
	assign trigWr      = wr && wb_adr_i[4:2] == OFS_TRIG[4:2];
	assign timerWr     = wr && wb_adr_i[4:2] == OFS_TIMER[4:2];
	assign statWr      = wr && wb_adr_i[4:2] == OFS_STATUS[4:2];
	assign ctrlMerged  = ({23'h0, ctrl_q} & ~byteMask(wb_sel_i)) | (wb_dat_i & byteMask(wb_sel_i));
	assign timerMerged = ({16'h0, reload_q} & ~byteMask(wb_sel_i)) | (wb_dat_i & byteMask(wb_sel_i));
	// unmapped addresses and the trigger register read as zero
	assign rdData = (wb_adr_i[4:2] == OFS_CTRL[4:2])   ? {23'h0, ctrl_q} :
	                (wb_adr_i[4:2] == OFS_TIMER[4:2])  ? {16'h0, cnt_q} :
	                (wb_adr_i[4:2] == OFS_STATUS[4:2]) ? {29'h0, out_q, state_q != CH_IDLE, irq_q} :
	                32'h0;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q    <= 1'b0;
			dat_q    <= 32'h0;
			ctrl_q   <= CTRL_RESET;
			reload_q <= TIMER_RESET;
		end else begin
			ack_q <= req;
			if (req)
				dat_q <= wb_we_i ? 32'h0 : rdData;
			if (ctrlWr)
				ctrl_q <= ctrl_t'(ctrlMerged[CTRL_W-1:0]);
			if (timerWr)
				reload_q <= timerMerged[15:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// event selection and two-phase decode
	logic swTrig, trigEv, useX4, cntUp, cntDn, runFall, irqSet, irqClr;
	logic [7:0] pwmN, pwmM;
	logic       step;

	assign swTrig  = trigWr & wb_sel_i[0] & wb_dat_i[0];
	assign trigEv  = (ctrl_q.trig == TRIG_SW)   ? swTrig :
	                 (ctrl_q.trig == TRIG_FALL) ? inFall :
	                 (ctrl_q.trig == TRIG_RISE) ? inRise :
	                 (ctrl_q.trig == TRIG_PREV) ? previousChannelOvf :
	                 (ctrl_q.trig == TRIG_NEXT) ? nextChannelOvf : 1'b0;
	assign useX4   = (CHANNEL == CH_X4) ? 1'b1 :
	                 (CHANNEL == CH_SELECT) ? ctrl_q.quadX4 : 1'b0;
	assign cntUp   = useX4 ? ((inRise & outLvl) | (inFall & ~outLvl) |
	                          (outRise & ~inLvl) | (outFall & inLvl)) : (inRise & outLvl);
	assign cntDn   = useX4 ? ((inFall & outLvl) | (inRise & ~outLvl) |
	                          (outRise & inLvl) | (outFall & ~inLvl)) : (inFall & outLvl);
	assign runFall = runPrev_q & ~ctrl_q.run;
	assign irqClr  = statWr & wb_sel_i[0] & wb_dat_i[ST_IRQ];
	assign pwmN    = reload_q[15:8];
	assign pwmM    = reload_q[7:0];
	assign step    = tick && pre_q == pwmM;

	////////////////////////////////////////////////////////////////
	// channel next-state
	always_comb begin
		cnt_d   = cnt_q;
		phase_d = phase_q;
		pre_d   = pre_q;
		state_d = state_q;
		out_d   = out_q;
		pend_d  = pend_q;
		ovf_d   = 1'b0;
		irqSet  = 1'b0;
		case (ctrl_q.mode)
			MODE_QUAD: begin
				state_d = CH_IDLE;
				out_d   = 1'b0;
				if (ctrl_q.run && (cntUp ^ cntDn)) begin
					if (cntUp) begin
						cnt_d = cnt_q + 16'h0001;
						if (cnt_q == CNT_MAX) begin
							irqSet = 1'b1;
							ovf_d  = 1'b1;
						end
					end else begin
						cnt_d = cnt_q - 16'h0001;
						if (cnt_q == 16'h0000) begin
							irqSet = 1'b1;
							ovf_d  = 1'b1;
						end
					end
				end
			end
			MODE_ONESHOT: begin
				if (runFall) begin
					state_d = CH_IDLE;
					cnt_d   = reload_q;
					out_d   = 1'b0;
					pend_d  = 1'b0;
					irqSet  = 1'b1;
				end else if (ctrl_q.run && state_q == CH_IDLE && trigEv) begin
					state_d = CH_ACTIVE;
					cnt_d   = reload_q;
					out_d   = 1'b1;
				end else if (ctrl_q.run && state_q == CH_ACTIVE) begin
					if (trigEv)
						pend_d = 1'b1;
					if (tick) begin
						if (pend_q | trigEv) begin
							cnt_d  = reload_q;
							pend_d = 1'b0;
						end else if (cnt_q <= 16'h0001) begin
							cnt_d   = reload_q;
							out_d   = 1'b0;
							state_d = CH_IDLE;
							irqSet  = 1'b1;
							ovf_d   = 1'b1;
						end else begin
							cnt_d = cnt_q - 16'h0001;
						end
					end
				end
			end
			MODE_PWM16: begin
				if (runFall) begin
					state_d = CH_IDLE;
					out_d   = 1'b0;
					irqSet  = out_q;
				end else if (ctrl_q.run && state_q == CH_IDLE && trigEv) begin
					state_d = CH_ACTIVE;
					phase_d = 16'h0000;
					cnt_d   = reload_q;
					out_d   = reload_q != 16'h0000;
				end else if (ctrl_q.run && state_q == CH_ACTIVE && tick) begin
					if (phase_q == PWM16_LAST) begin
						phase_d = 16'h0000;
						cnt_d   = reload_q;
						out_d   = reload_q != 16'h0000;
						ovf_d   = 1'b1;
					end else begin
						phase_d = phase_q + 16'h0001;
						if (cnt_q != 16'h0000) begin
							cnt_d = cnt_q - 16'h0001;
							if (cnt_q == 16'h0001) begin
								out_d  = 1'b0;
								irqSet = 1'b1;
							end
						end
					end
				end
			end
			MODE_PWM8: begin
				if (ctrl_q.run && tick && state_q != CH_IDLE)
					pre_d = step ? 8'h00 : pre_q + 8'h01;
				if (runFall) begin
					state_d = CH_IDLE;
					out_d   = 1'b0;
					irqSet  = out_q;
				end else if (ctrl_q.run && state_q == CH_IDLE && trigEv) begin
					state_d = CH_DELAY;
					cnt_d   = {8'h00, pwmN};
					pre_d   = 8'h00;
					out_d   = 1'b0;
				end else if (ctrl_q.run && state_q == CH_DELAY && step) begin
					if (cnt_q <= 16'h0001) begin
						state_d = CH_ACTIVE;
						phase_d = 16'h0000;
						cnt_d   = {8'h00, pwmN};
						out_d   = pwmN != 8'h00;
					end else begin
						cnt_d = cnt_q - 16'h0001;
					end
				end else if (ctrl_q.run && state_q == CH_ACTIVE && step) begin
					if (phase_q[7:0] == PWM8_LAST) begin
						phase_d = 16'h0000;
						cnt_d   = {8'h00, pwmN};
						out_d   = pwmN != 8'h00;
						ovf_d   = 1'b1;
					end else begin
						phase_d = phase_q + 16'h0001;
						if (cnt_q != 16'h0000) begin
							cnt_d = cnt_q - 16'h0001;
							if (cnt_q == 16'h0001) begin
								out_d  = 1'b0;
								irqSet = 1'b1;
							end
						end
					end
				end
			end
			default: begin
				state_d = CH_IDLE;
				out_d   = 1'b0;
			end
		endcase
		// a stopped counter takes a written value so counting starts from it
		if (timerWr && !ctrl_q.run)
			cnt_d = timerMerged[15:0];
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q     <= TIMER_RESET;
			phase_q   <= 16'h0000;
			pre_q     <= 8'h00;
			state_q   <= CH_IDLE;
			out_q     <= 1'b0;
			oe_q      <= 1'b0;
			pend_q    <= 1'b0;
			ovf_q     <= 1'b0;
			irq_q     <= 1'b0;
			runPrev_q <= 1'b0;
		end else begin
			cnt_q     <= cnt_d;
			phase_q   <= phase_d;
			pre_q     <= pre_d;
			state_q   <= state_d;
			out_q     <= out_d;
			// phase pins stay undriven while decoding
			oe_q      <= ctrl_q.mode != MODE_QUAD;
			pend_q    <= pend_d;
			ovf_q     <= ovf_d;
			// set beats a clear in the same cycle
			irq_q     <= irqSet | (irq_q & ~irqClr);
			runPrev_q <= ctrl_q.run;
		end
	end

	assign wb_dat_o          = dat_q;
	assign wb_ack_o          = ack_q;
	assign timerOutputPinOut = out_q;
	assign timerOutputPinOe  = oe_q;
	assign channelOvf        = ovf_q;
	assign irqReq            = irq_q;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic quadRun;
	assign quadRun = ctrl_q.mode == MODE_QUAD && ctrl_q.run && !timerWr && !ctrlWr;

	property p_quad_up;
		quadRun && cntUp && !cntDn && cnt_q != CNT_MAX |=> cnt_q == 16'($past(cnt_q) + 16'h0001);
	endproperty
	a_quad_up: assert property (p_quad_up) else $error("two-phase up edge not counted");

	property p_wrap_up;
		quadRun && cntUp && !cntDn && cnt_q == CNT_MAX |=> cnt_q == 16'h0000 && irq_q && channelOvf;
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("overflow did not wrap");

	property p_wrap_dn;
		quadRun && cntDn && !cntUp && cnt_q == 16'h0000 |=> cnt_q == CNT_MAX && irq_q;
	endproperty
	a_wrap_dn: assert property (p_wrap_dn) else $error("underflow did not wrap");

	property p_os_start;
		ctrl_q.mode == MODE_ONESHOT && ctrl_q.run && !ctrlWr && state_q == CH_IDLE && trigEv
			|=> timerOutputPinOut && state_q == CH_ACTIVE;
	endproperty
	a_os_start: assert property (p_os_start) else $error("one-shot did not start");

	property p_os_end;
		ctrl_q.mode == MODE_ONESHOT && ctrl_q.run && !ctrlWr && !timerWr && state_q == CH_ACTIVE
			&& tick && cnt_q == 16'h0001 && !pend_q && !trigEv
			|=> !timerOutputPinOut && state_q == CH_IDLE && irq_q && cnt_q == reload_q;
	endproperty
	a_os_end: assert property (p_os_end) else $error("one-shot end wrong");

	sequence s_retrig;
		ctrl_q.mode == MODE_ONESHOT && ctrl_q.run && state_q == CH_ACTIVE && trigEv && !tick && !ctrlWr
			##1 tick && ctrl_q.run && !ctrlWr && !timerWr;
	endsequence
	property p_retrig;
		s_retrig |=> cnt_q == reload_q && state_q == CH_ACTIVE;
	endproperty
	a_retrig: assert property (p_retrig) else $error("retrigger did not reload");

	property p_os_stop;
		ctrl_q.mode == MODE_ONESHOT && runFall && !ctrlWr |=> !timerOutputPinOut && irq_q && state_q == CH_IDLE;
	endproperty
	a_os_stop: assert property (p_os_stop) else $error("one-shot stop wrong");

	property p_pwm_stop;
		(ctrl_q.mode == MODE_PWM16 || ctrl_q.mode == MODE_PWM8) && runFall && !timerWr && !ctrlWr
			|=> !timerOutputPinOut && cnt_q == $past(cnt_q);
	endproperty
	a_pwm_stop: assert property (p_pwm_stop) else $error("pwm stop did not freeze");

	property p_pwm_fall;
		ctrl_q.mode == MODE_PWM16 && ctrl_q.run && !ctrlWr && state_q == CH_ACTIVE && tick
			&& cnt_q == 16'h0001 && phase_q != PWM16_LAST |=> !timerOutputPinOut && irq_q;
	endproperty
	a_pwm_fall: assert property (p_pwm_fall) else $error("pwm high time end wrong");

	property p_pwm16_zero;
		ctrl_q.mode == MODE_PWM16 && reload_q == 16'h0000 && !timerWr && !ctrlWr && !timerOutputPinOut
			|=> !timerOutputPinOut;
	endproperty
	a_pwm16_zero: assert property (p_pwm16_zero) else $error("zero width pwm drove high");

	property p_pwm8_delay;
		ctrl_q.mode == MODE_PWM8 && ctrl_q.run && !ctrlWr && state_q == CH_IDLE && trigEv && pwmM != 8'h00
			|=> !timerOutputPinOut && state_q == CH_DELAY ##1 !timerOutputPinOut;
	endproperty
	a_pwm8_delay: assert property (p_pwm8_delay) else $error("8-bit pwm skipped low lead");

endmodule : multimode_timer_channel

/* File: tb/quad_source.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// encoder phases and trigger level on the channel's two pins
module quad_source (
	input  wire logic clk,
	output logic      phaseA,
	output logic      phaseB
);
	logic [1:0] idx = 2'h0;
	initial begin
		phaseA = 1'b0;
		phaseB = 1'b0;
	end
	// gray walk 00,01,11,10 is up; one phase moves per step
	// in two-phase mode the pins stay inputs of the channel, driven from here only
	task automatic step(input bit up);
		logic [1:0] nx;
		nx = up ? idx + 2'h1 : idx - 2'h1;
		@(posedge clk);
		idx    <= nx;
		phaseA <= nx[1];
		phaseB <= nx[1] ^ nx[0];
		// held past the pin synchroniser
		repeat (4) @(posedge clk);
	endtask : step
	task automatic setA(input logic v);
		@(posedge clk);
		phaseA <= v;
		repeat (4) @(posedge clk);
	endtask : setA
endmodule : quad_source

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import timer_pkg::*;
	logic        clk, rstn, cyc, stb, we;
	logic        subclk, prevOvf, nextOvf, pinB;
	logic [4:0]  adr;
	logic [3:0]  sel, selW;
	logic [31:0] datI, datO, rd, t0;
	logic        ack, pinOut, oe, chOvf, irq, phaseA, phaseB;
	logic [2:0]  subCnt = 3'h0;
	int          errTotal = 0, cmpCount = 0, cycles = 0, n, ovfCnt = 0;
	int          divs[4] = '{1, 8, 32, 256};
	assign pinB = oe ? pinOut : phaseB;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		subCnt <= subCnt + 3'h1;
		subclk <= subCnt[2];
		cycles <= cycles + 1;
		// overflow output is a one-cycle pulse: counted here, judged later
		if (chOvf === 1'b1)
			ovfCnt <= ovfCnt + 1;
		// whole plan needs about 70k cycles
		if (cycles == 100000) begin
			errTotal++;
			test_done();
		end
	end
	multimode_timer_channel #(.CHANNEL(3)) u_multimode_timer_channel (.clk(clk), .rstn(rstn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .timerInputPin(phaseA),
		.timerOutputPinIn(pinB), .timerOutputPinOut(pinOut), .timerOutputPinOe(oe),
		.subclk(subclk), .previousChannelOvf(prevOvf), .nextChannelOvf(nextOvf),
		.channelOvf(chOvf), .irqReq(irq));
	quad_source src (.clk(clk), .phaseA(phaseA), .phaseB(phaseB));
////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("errors %0d, checks %0d", errTotal, cmpCount);
		if (errTotal == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmpCount++;
		if (g !== e) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chkIn(input string nm, input int lo, input int hi, input int g);
		cmpCount++;
		if (g < lo || g > hi) begin
			errTotal++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chkIn
	// one classic cycle; the answer is waited for, never assumed
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= selW;
		datI <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		sel <= 4'h0;
	endtask : wb
	function automatic logic [31:0] ctl(mode_t m, trig_t t, src_t s, logic r);
		ctrl_t c;
		c = '{quadX4: 1'b1, src: s, trig: t, mode: m, run: r};
		return {23'h0, c};
	endfunction : ctl
	// counts settled cycles while the output keeps level v
	// a call made at a negedge counts that one too, so back-to-back calls lose no cycle
	task automatic hold(input logic v, input int mx);
		n = 0;
		if (clk !== 1'b0)
			@(negedge clk);
		while (pinOut === v && n < mx) begin
			n++;
			@(negedge clk);
		end
	endtask : hold
	task automatic clr();
		wb(1, OFS_STATUS, 32'h1);
	endtask : clr
////////////////////////////////////////////////////////////////////////////////
	task automatic t_quad();
		wb(1, OFS_TIMER, 32'h2);
		wb(1, OFS_CTRL, ctl(MODE_QUAD, TRIG_SW, SRC_DIV1, 1));
		chk("oe", 0, oe);
		repeat (3) src.step(0);
		wb(0, OFS_TIMER, 0);
		chk("under", 32'hffff, rd);
		chk("irqU", 1, irq);
		clr();
		src.step(1);
		wb(0, OFS_TIMER, 0);
		chk("over", 32'h0, rd);
		chk("irqO", 1, irq);
		chk("ovfQ", 2, ovfCnt);
		repeat (4) src.step(1);
		src.step(0);
		wb(0, OFS_TIMER, 0);
		chk("x4", 32'h3, rd);
		// normal decode: the phase-B edge of the second step must not count
		wb(1, OFS_CTRL, ctl(MODE_QUAD, TRIG_SW, SRC_DIV1, 1) & 32'hfffffeff);
		src.step(1);
		src.step(1);
		wb(0, OFS_TIMER, 0);
		chk("norm", 32'h4, rd);
		wb(1, OFS_CTRL, 0);
		clr();
	endtask : t_quad
	task automatic t_shot();
		for (int s = 0; s < 4; s++) begin
			wb(1, OFS_CTRL, ctl(MODE_ONESHOT, TRIG_SW, src_t'(s), 0));
			wb(1, OFS_TIMER, 32'h2);
			wb(1, OFS_CTRL, ctl(MODE_ONESHOT, TRIG_SW, src_t'(s), 1));
			clr();
			wb(1, OFS_TRIG, 32'h1);
			chk("high", 1, pinOut);
			chk("oeS", 1, oe);
			hold(1, 2000);
			chkIn("shot", divs[s], 3 * divs[s], n);
			chk("irqS", 1, irq);
			wb(0, OFS_TIMER, 0);
			chk("reld", 32'h2, rd);
		end
		// div8 so the reload has to wait for the next tick after the retrigger
		wb(1, OFS_CTRL, ctl(MODE_ONESHOT, TRIG_SW, SRC_DIV8, 0));
		wb(1, OFS_TIMER, 32'h40);
		wb(1, OFS_CTRL, ctl(MODE_ONESHOT, TRIG_SW, SRC_DIV8, 1));
		wb(1, OFS_TRIG, 32'h1);
		repeat (20) @(posedge clk);
		wb(1, OFS_TRIG, 32'h1);
		hold(1, 700);
		chkIn("retrig", 511, 518, n);
		wb(1, OFS_TRIG, 32'h1);
		repeat (10) @(posedge clk);
		clr();
		wb(1, OFS_CTRL, ctl(MODE_ONESHOT, TRIG_SW, SRC_DIV1, 0));
		@(negedge clk);
		chk("stopO", 0, pinOut);
		chk("stopI", 1, irq);
		wb(0, OFS_TIMER, 0);
		chk("stopR", 32'h40, rd);
	endtask : t_shot
	task automatic t_src();
		for (int t = 1; t < 5; t++) begin
			wb(1, OFS_TIMER, 32'h100);
			src.setA(t == 1);
			wb(1, OFS_CTRL, ctl(MODE_ONESHOT, trig_t'(t), SRC_DIV1, 1));
			chk("idle", 0, pinOut);
			if (t < 3)
				src.setA(t == 2);
			@(posedge clk);
			prevOvf <= (t == 3);
			nextOvf <= (t == 4);
			@(posedge clk);
			prevOvf <= 1'b0;
			nextOvf <= 1'b0;
			hold(0, 20);
			chk("start", 1, pinOut);
			wb(1, OFS_CTRL, 0);
		end
		clr();
	endtask : t_src
	task automatic t_pwm16();
		src.setA(0);
		wb(1, OFS_TIMER, 32'h3);
		wb(1, OFS_CTRL, ctl(MODE_PWM16, TRIG_RISE, SRC_DIV1, 1));
		clr();
		src.setA(1);
		hold(0, 20);
		chk("rise", 1, pinOut);
		// first pulse is already under way: width is judged on the second one
		hold(1, 20);
		chk("irq16", 1, irq);
		hold(0, 70000);
		chk("p16", 65532, n);
		hold(1, 20);
		chk("w16", 3, n);
		repeat (10) @(posedge clk);
		wb(1, OFS_CTRL, ctl(MODE_PWM16, TRIG_RISE, SRC_DIV1, 0));
		wb(0, OFS_TIMER, 0);
		t0 = rd;
		repeat (10) @(posedge clk);
		wb(0, OFS_TIMER, 0);
		chk("frz", t0, rd);
		chk("off", 0, pinOut);
		wb(1, OFS_TIMER, 32'h0);
		wb(1, OFS_CTRL, ctl(MODE_PWM16, TRIG_RISE, SRC_DIV1, 1));
		src.setA(0);
		src.setA(1);
		hold(0, 100);
		chk("zero16", 0, pinOut);
		wb(1, OFS_CTRL, 0);
	endtask : t_pwm16
	task automatic t_pwm8();
		src.setA(1);
		wb(1, OFS_TIMER, 32'h209);
		wb(1, OFS_CTRL, ctl(MODE_PWM8, TRIG_FALL, SRC_DIV1, 1));
		clr();
		src.setA(0);
		hold(0, 100);
		chkIn("lead", 8, 20, n);
		hold(1, 100);
		chk("w8", 20, n);
		chk("irq8", 1, irq);
		hold(0, 3000);
		chk("p8", 2530, n);
		wb(1, OFS_CTRL, ctl(MODE_PWM8, TRIG_FALL, SRC_DIV1, 0));
		@(negedge clk);
		chk("off8", 0, pinOut);
		wb(1, OFS_TIMER, 32'h9);
		wb(1, OFS_CTRL, ctl(MODE_PWM8, TRIG_FALL, SRC_DIV1, 1));
		src.setA(1);
		src.setA(0);
		hold(0, 600);
		chk("zero8", 0, pinOut);
	endtask : t_pwm8
////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk     = 1'b0;
		rstn    = 1'b0;
		cyc     = 1'b0;
		stb     = 1'b0;
		we      = 1'b0;
		adr     = 5'h00;
		sel     = 4'h0;
		selW    = 4'hf;
		datI    = 32'h0;
		subclk  = 1'b0;
		prevOvf = 1'b0;
		nextOvf = 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		wb(0, 5'h10, 0);
		chk("unmap", 0, rd);
		wb(0, OFS_CTRL, 0);
		chk("ctrl0", 0, rd);
		// byte lanes: only the low byte of the second write may land
		wb(1, OFS_TIMER, 32'h5a5a);
		selW = 4'h1;
		wb(1, OFS_TIMER, 32'h00c3);
		selW = 4'hf;
		wb(0, OFS_TIMER, 0);
		chk("sel", 32'h5ac3, rd);
		t_quad();
		t_shot();
		t_src();
		t_pwm16();
		t_pwm8();
		test_done();
	end
endmodule : tb
